// [hdl/csf_regs.sv]
`timescale 1ns/10ps
`default_nettype none
`include "csf_cfg.svh"
module csf_regs
    import csf_pkg::*;
(
    input  wire logic       clk,                   // serial port clock
    input  wire logic       rst,                   // power-on reset
    input  wire csf_req_s   req,                   // decoded register access
    output logic      [7:0] rdata,                 // read data, valid one cycle after rd
    output logic            rvalid,                // read data strobe
    output csf_cfg_s        cfg,                   // configuration fields
    output logic      [3:0] out_cmos_active,       // output n in CMOS format
    output logic      [3:0] out_enabled,           // output n not disabled
    output logic            manual_select_valid,   // active_input_select applies
    output logic      [1:0] active_input_select,   // chosen input in manual mode
    input  wire logic       pin_select_enable,     // pins control manual selection
    input  wire logic [1:0] register_input_select, // register clock-select field
    input  wire logic [1:0] select_pins            // external select pins, asynchronous
);
    logic [7:0] isc_r, isc_nxt;
    logic [7:0] ofl_r, ofl_nxt;
    logic [7:0] ofh_r, ofh_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic       rvalid_r, rvalid_nxt;
    csf_cfg_s   cfg_r, cfg_nxt;
    logic [3:0] cmos_r, cmos_nxt;
    logic [3:0] en_r, en_nxt;
    logic       msv_r, msv_nxt;
    logic [1:0] ais_r, ais_nxt;
    logic [1:0] pins_sync;

    function automatic logic is_cmos(input logic [2:0] f);
        is_cmos = (f == CSF_FMT_CMOS);
    endfunction

    function automatic logic is_enabled(input logic [2:0] f);
        // reserved codes are treated as not driving
        is_enabled = (f != CSF_FMT_DISABLE) && (f != CSF_FMT_RSVD0) && (f != CSF_FMT_RSVD4);
    endfunction

    csf_pin_sync u_pin_sync (
        .clk     (clk),
        .rst     (rst),
        .pin_in  (select_pins),
        .pin_out (pins_sync)
    );

    // register writes; masked bits are reserved and never stored
    always_comb begin
        isc_nxt = isc_r;
        ofl_nxt = ofl_r;
        ofh_nxt = ofh_r;
        if (req.wr) begin
            if (req.addr == `CSF_ADDR_INPUT_SELECT_CONFIG) begin
                isc_nxt = req.wdata & `CSF_MASK_INPUT_SELECT_CONFIG;
            end else if (req.addr == `CSF_ADDR_OUTPUT_FORMAT_LOW) begin
                ofl_nxt = req.wdata & `CSF_MASK_OUTPUT_FORMAT_LOW;
            end else if (req.addr == `CSF_ADDR_OUTPUT_FORMAT_HIGH) begin
                ofh_nxt = req.wdata & `CSF_MASK_OUTPUT_FORMAT_HIGH;
            end
        end
    end

    // reads show the stored value; unmapped addresses answer zero
    always_comb begin
        rdata_nxt  = rdata_r;
        rvalid_nxt = req.rd;
        if (req.rd) begin
            if (req.addr == `CSF_ADDR_INPUT_SELECT_CONFIG) begin
                rdata_nxt = isc_r & `CSF_MASK_INPUT_SELECT_CONFIG;
            end else if (req.addr == `CSF_ADDR_OUTPUT_FORMAT_LOW) begin
                rdata_nxt = ofl_r;
            end else if (req.addr == `CSF_ADDR_OUTPUT_FORMAT_HIGH) begin
                rdata_nxt = ofh_r & `CSF_MASK_OUTPUT_FORMAT_HIGH;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    // field views follow the stored registers one cycle later
    always_comb begin
        cfg_nxt.selection_method    = isc_r[`CSF_SEL_METHOD_MSB:`CSF_SEL_METHOD_LSB];
        cfg_nxt.history_delay       = isc_r[`CSF_HIST_DELAY_MSB:`CSF_HIST_DELAY_LSB];
        cfg_nxt.cmos_drive_strength = ofl_r[`CSF_DRIVE_MSB:`CSF_DRIVE_LSB];
        cfg_nxt.out2_format         = ofl_r[`CSF_FMT_HI_MSB:`CSF_FMT_HI_LSB];
        cfg_nxt.out1_format         = ofl_r[`CSF_FMT_LO_MSB:`CSF_FMT_LO_LSB];
        cfg_nxt.out4_format         = ofh_r[`CSF_FMT_HI_MSB:`CSF_FMT_HI_LSB];
        cfg_nxt.out3_format         = ofh_r[`CSF_FMT_LO_MSB:`CSF_FMT_LO_LSB];
        // drive strength only matters where the buffer is in CMOS format
        cmos_nxt = {is_cmos(ofh_r[5:3]), is_cmos(ofh_r[2:0]), is_cmos(ofl_r[5:3]), is_cmos(ofl_r[2:0])};
        en_nxt   = {is_enabled(ofh_r[5:3]), is_enabled(ofh_r[2:0]),
                    is_enabled(ofl_r[5:3]), is_enabled(ofl_r[2:0])};
        // no power-budget enforcement here: legal output mixes are software's job
    end

    // manual selection: pins override the register field when pin control is on
    always_comb begin
        msv_nxt = (isc_r[`CSF_SEL_METHOD_MSB:`CSF_SEL_METHOD_LSB] == CSF_SEL_MANUAL);
        ais_nxt = ais_r;
        if (msv_nxt) begin
            if (pin_select_enable) begin
                ais_nxt = pins_sync;
            end else begin
                ais_nxt = register_input_select;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            isc_r    <= `CSF_RST_INPUT_SELECT_CONFIG;
            ofl_r    <= `CSF_RST_OUTPUT_FORMAT_LOW;
            ofh_r    <= `CSF_RST_OUTPUT_FORMAT_HIGH;
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
            cfg_r    <= '0;
            cmos_r   <= 4'h0;
            en_r     <= 4'h0;
            msv_r    <= 1'b0;
            ais_r    <= 2'h0;
        end else begin
            isc_r    <= isc_nxt;
            ofl_r    <= ofl_nxt;
            ofh_r    <= ofh_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            cfg_r    <= cfg_nxt;
            cmos_r   <= cmos_nxt;
            en_r     <= en_nxt;
            msv_r    <= msv_nxt;
            ais_r    <= ais_nxt;
        end
    end

    assign rdata               = rdata_r;
    assign rvalid              = rvalid_r;
    assign cfg                 = cfg_r;
    assign out_cmos_active     = cmos_r;
    assign out_enabled         = en_r;
    assign manual_select_valid = msv_r;
    assign active_input_select = ais_r;
endmodule
`default_nettype wire

// [hdl/csf_cfg.svh]
// Summary of operation
// - register 4 bits 7:6 pick manual, automatic non-revertive or revertive selection
// - register 4 bits 4:0 hold the holdover history generation delay
// - register 5 bits 7:6 set CMOS drive strength, used only by CMOS outputs
// - three-bit format codes: disable, CMOS, low-swing LVDS, LVPECL, CML, LVDS
// - register 5 holds output two format in 5:3, output one in 2:0
// - register 6 holds output four in 5:3, output three in 2:0, 7:6 read-only
// - reset loads register 4 with 0x12, register 5 with 0xed, register 6 with 0x2c
// - manual mode: register select unless pin control is on, then pins decide
`ifndef CSF_CFG_SVH
`define CSF_CFG_SVH

`define CSF_ADDR_INPUT_SELECT_CONFIG   8'h04
`define CSF_ADDR_OUTPUT_FORMAT_LOW     8'h05
`define CSF_ADDR_OUTPUT_FORMAT_HIGH    8'h06

`define CSF_RST_INPUT_SELECT_CONFIG    8'h12
`define CSF_RST_OUTPUT_FORMAT_LOW      8'hed
`define CSF_RST_OUTPUT_FORMAT_HIGH     8'h2c

`define CSF_MASK_INPUT_SELECT_CONFIG   8'hdf
`define CSF_MASK_OUTPUT_FORMAT_LOW     8'hff
`define CSF_MASK_OUTPUT_FORMAT_HIGH    8'h3f

`define CSF_SEL_METHOD_MSB             7
`define CSF_SEL_METHOD_LSB             6
`define CSF_HIST_DELAY_MSB             4
`define CSF_HIST_DELAY_LSB             0
`define CSF_DRIVE_MSB                  7
`define CSF_DRIVE_LSB                  6
`define CSF_FMT_HI_MSB                 5
`define CSF_FMT_HI_LSB                 3
`define CSF_FMT_LO_MSB                 2
`define CSF_FMT_LO_LSB                 0

`endif

// [hdl/csf_pkg.sv]
package csf_pkg;

    typedef enum logic [1:0] {
        CSF_SEL_MANUAL,
        CSF_SEL_AUTO_NONREVERT,
        CSF_SEL_AUTO_REVERT,
        CSF_SEL_RESERVED
    } csf_sel_method_e;

    typedef enum logic [2:0] {
        CSF_FMT_RSVD0,
        CSF_FMT_DISABLE,
        CSF_FMT_CMOS,
        CSF_FMT_LVDS_LOW_SWING,
        CSF_FMT_RSVD4,
        CSF_FMT_LVPECL,
        CSF_FMT_CML,
        CSF_FMT_LVDS
    } csf_fmt_e;

    typedef struct packed {
        logic [1:0] selection_method;
        logic [4:0] history_delay;
        logic [1:0] cmos_drive_strength;
        logic [2:0] out1_format;
        logic [2:0] out2_format;
        logic [2:0] out3_format;
        logic [2:0] out4_format;
    } csf_cfg_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csf_req_s;

endpackage

// [hdl/csf_pin_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module csf_pin_sync (
    input  wire logic       clk,    // port clock
    input  wire logic       rst,    // sync reset
    input  wire logic [1:0] pin_in, // asynchronous pins
    output logic      [1:0] pin_out // filtered level
);
    logic [1:0] s1_r, s2_r, s3_r, q_r;
    logic [1:0] q_nxt;

    // only accept a new level once the second and third stages agree
    always_comb begin
        q_nxt = q_r;
        if (s2_r == s3_r) begin
            q_nxt = s3_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= 2'h0;
            s2_r <= 2'h0;
            s3_r <= 2'h0;
            q_r  <= 2'h0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= q_nxt;
        end
    end

    assign pin_out = q_r;
endmodule
`default_nettype wire

// [test/csf_regs_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module csf_regs_chk
    import csf_pkg::*;
(
    input wire logic       clk,                   // clock
    input wire logic       rst,                   // reset
    input wire csf_req_s   req,                   // access
    input wire logic [7:0] rdata,                 // data
    input wire logic       rvalid,                // strobe
    input wire csf_cfg_s   cfg,                   // fields
    input wire logic [3:0] out_cmos_active,       // cmos
    input wire logic [3:0] out_enabled,           // on
    input wire logic       manual_select_valid,   // manual
    input wire logic [1:0] active_input_select,   // chosen
    input wire logic       pin_select_enable,     // pins rule
    input wire logic [1:0] register_input_select, // reg pick
    input wire logic [1:0] select_pins            // pins
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic w4 = req.wr && req.addr == 8'h04;
    function automatic logic on(logic [2:0] f);
        return !(f inside {3'h0, 3'h1, 3'h4});
    endfunction
    a_reset_load: assert property ($fell(rst) |=> manual_select_valid &&
        cfg == {2'h0, 5'h12, 2'h3, 3'h5, 3'h5, 3'h4, 3'h5}) else $error("bad reset fields");
    a_method_write: assert property (w4 |-> ##2 cfg.selection_method == $past(req.wdata[7:6], 2))
        else $error("method not stored");
    a_hist_write: assert property (w4 |-> ##2 cfg.history_delay == $past(req.wdata[4:0], 2))
        else $error("delay not stored");
    a_low_write: assert property (req.wr && req.addr == 8'h05 |-> ##2
        {cfg.cmos_drive_strength, cfg.out2_format, cfg.out1_format} == $past(req.wdata, 2)) else $error("reg5 bad");
    a_high_write: assert property (req.wr && req.addr == 8'h06 |-> ##2
        {cfg.out4_format, cfg.out3_format} == $past(req.wdata[5:0], 2)) else $error("reg6 bad");
    a_format_flags: assert property (out_enabled == {on(cfg.out4_format), on(cfg.out3_format),
        on(cfg.out2_format), on(cfg.out1_format)}) else $error("enable flags bad");
    a_manual_flag: assert property (!$fell(rst) |-> manual_select_valid == (cfg.selection_method == 2'h0))
        else $error("manual flag bad");
    a_reg_select: assert property ((manual_select_valid && !pin_select_enable && $stable(register_input_select))[*3]
        |-> active_input_select == register_input_select) else $error("register pick bad");
    a_pin_select: assert property ((manual_select_valid && pin_select_enable && $stable(select_pins))[*8]
        |-> active_input_select == select_pins) else $error("pin pick bad");
    a_rsvd_read: assert property (req.rd && req.addr == 8'h06 |=> rdata[7:6] == 2'h0)
        else $error("reserved bits read back");
    a_unmapped_read: assert property (req.rd && req.addr > 8'h06 |=> rvalid && rdata == 8'h00)
        else $error("unmapped read not zero");
    c_write: cover property (w4);
    c_rd_wr: cover property (req.rd && req.wr);
    c_pins: cover property (manual_select_valid && pin_select_enable);
endmodule
bind csf_regs csf_regs_chk i_csf_regs_chk (.*);
`default_nettype wire

// [test/csf_host.sv]
`timescale 1ns/10ps
`default_nettype none
module csf_host
    import csf_pkg::*;
(
    input  wire logic   clk, // port clock
    output var csf_req_s req // strobes
);
    initial req = '0;
    // one assignment per falling edge, so back-to-back requests never race
    task automatic acc(input logic w, r, input logic [7:0] a, d);
        @(negedge clk);
        req <= '{w, r, a, d};
    endtask
endmodule
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
    import csf_pkg::*;
    logic clk = 0, rst = 1, pse = 0, rvalid, msv;
    logic [1:0] rsel = 0, pins = 0, act;
    logic [3:0] cm, en;
    logic [7:0] rdata, sh[8], rd_q[$];
    csf_req_s req;
    csf_cfg_s cfg;
    int miscompares = 0, checked = 0, seed = 67441;
    always #4 clk = ~clk;
    csf_host i_csf_host (.clk(clk), .req(req));
    csf_regs i_csf_regs (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid), .cfg(cfg),
        .out_cmos_active(cm), .out_enabled(en), .manual_select_valid(msv), .active_input_select(act),
        .pin_select_enable(pse), .register_input_select(rsel), .select_pins(pins));
    task automatic check(input logic [7:0] got, exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        if (miscompares == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, d);
        i_csf_host.acc(1, 0, a, d);
        if (a inside {4, 5, 6}) sh[a[2:0]] = d & (a == 4 ? 8'hdf : a == 5 ? 8'hff : 8'h3f);
    endtask
    task automatic rd(input logic [7:0] a);
        i_csf_host.acc(0, 1, a, 8'h00);
        rd_q.push_back(a inside {4, 5, 6} ? sh[a[2:0]] : 8'h00);
    endtask
    always @(negedge clk) if (rvalid === 1'b1) check(rdata, rd_q.pop_front());
    initial begin
        #(8 * 3000);
        miscompares++;
        results;
    end
    initial begin
        sh[4] = 8'h12;
        sh[5] = 8'hed;
        sh[6] = 8'h2c;
        repeat (6) @(negedge clk);
        rst = 0;
        for (int a = 3; a < 8; a++) rd(a[7:0]);
        for (int a = 3; a < 8; a++) wr(a[7:0], 8'hff);
        for (int a = 3; a < 8; a++) rd(a[7:0]);
        // read and write together: the read sees the old byte
        i_csf_host.acc(1, 1, 8'h05, 8'h5a);
        rd_q.push_back(sh[5]);
        sh[5] = 8'h5a;
        rd(8'h05);
        for (int c = 0; c < 8; c++) begin
            wr(8'h05, {2'h0, c[2:0], c[2:0]});
            wr(8'h06, {2'h0, c[2:0], c[2:0]});
            i_csf_host.acc(0, 0, 8'h00, 8'h00);
            repeat (3) @(negedge clk);
            check({4'h0, en}, {4'h0, {4{!(c inside {0, 1, 4})}}});
            check({4'h0, cm}, {4'h0, {4{c == 2}}});
        end
        for (int i = 0; i < 24; i++) begin
            wr(8'h05, 8'($random(seed)));
            wr(8'h04, {i[1:0], 1'b0, 5'($random(seed))});
            i_csf_host.acc(0, 0, 8'h00, 8'h00);
            pse = i[2];
            rsel = 2'($random(seed));
            pins = 2'($random(seed));
            repeat (10) @(negedge clk);
            check({7'h0, msv}, {7'h0, i[1:0] == 2'h0});
            if (i[1:0] == 0) check({6'h0, act}, {6'h0, pse ? pins : rsel});
            rd(8'h04);
            rd(8'h05);
        end
        i_csf_host.acc(0, 0, 8'h00, 8'h00);
        repeat (4) @(negedge clk);
        check(8'(rd_q.size()), 8'h00);
        results;
    end
endmodule
`default_nettype wire
